// *** common/ppbi_pkg.sv ***
// Types shared by the printer/plotter bus interface
package ppbi_pkg;
   typedef enum logic [1:0] {PPBI_DATI, PPBI_DATIP, PPBI_DATO, PPBI_DATOB} ppbi_bus_op_t;
   typedef struct packed {
      logic [17:0]  addr;
      ppbi_bus_op_t op;
      logic         msyn;
      logic [15:0]  wdata;
   } ppbi_bus_req_t;
   typedef struct packed {
      logic [7:0] data;
      logic       strobe;
      logic       prime_n;
   } ppbi_prn_out_t;
   typedef struct packed {
      logic buffer_clear_n;
      logic eot_n;
      logic form_feed_n;
      logic line_term_n;
   } ppbi_remote_t;
   typedef enum {PPBI_IDLE, PPBI_REQ, PPBI_MASTER, PPBI_LOCKOUT} ppbi_irq_state_t;
   typedef enum {PPBI_P_IDLE, PPBI_P_SETTLE, PPBI_P_STROBE, PPBI_P_WAIT, PPBI_P_GAP} ppbi_prn_state_t;
endpackage

// *** common/ppbi_regs.svh ***
// Register offsets, field positions, reset values and timing constants
`ifndef PPBI_REGS_SVH
`define PPBI_REGS_SVH
`define PPBI_SEL_STATUS      2'b10
`define PPBI_SEL_DATA        2'b11
`define PPBI_STATUS_OFFSET   3'h4
`define PPBI_DATA_OFFSET     3'h6
`define PPBI_BIT_MODE        0
`define PPBI_BIT_LINE_TERM   1
`define PPBI_BIT_EOT         2
`define PPBI_BIT_FORM_FEED   3
`define PPBI_BIT_BUFFER_CLEAR     4
`define PPBI_BIT_IE          6
`define PPBI_BIT_DONE        7
`define PPBI_BIT_ERROR       15
`define PPBI_CODE_LF         8'h0a
`define PPBI_CODE_FF         8'h0c
`define PPBI_CR_LOW3         3'h5
`define PPBI_VECTOR_RESET    7'h20
`define PPBI_CLK_PS          5000
`define PPBI_SETTLE_NS       500
`define PPBI_STROBE_NS       500
`define PPBI_REM_PULSE_NS    500
`define PPBI_SECOND_NS       200
`define PPBI_GATE_NS         100
`define PPBI_ERROR_MS        400
`define PPBI_CYC_NS(ns)      (((ns) * 1000 + `PPBI_CLK_PS - 1) / `PPBI_CLK_PS)
`define PPBI_ERROR_CYCLES    (`PPBI_ERROR_MS * 200000)
`endif

// *** dv/ppbi_core_props.sv ***
// Port-level assertions for the printer/plotter bus interface
`timescale 1ns/1ps
`default_nettype none
`include "ppbi_regs.svh"
module ppbi_core_props #(
   parameter logic [17:3] DEV_ADDR = 15'h7fe9,
   parameter logic [6:0]  VECTOR   = 7'h20,
   parameter int          PRIORITY = 4
) (
   // Clock and reset
   input wire logic                    clock_i,
   input wire logic                    rst_i,
   // Bus and printer ports
   input wire ppbi_pkg::ppbi_bus_req_t bus_req_i,
   input wire logic                    bus_init_i,
   input wire logic                    bus_ssyn_o,
   input wire logic                    bus_bg_in_i,
   input wire logic                    bus_bbsy_i,
   input wire logic                    bus_ssyn_in_i,
   input wire logic [7:4]              bus_br_o,
   input wire logic                    bus_bg_out_o,
   input wire logic                    bus_sack_o,
   input wire logic                    bus_bbsy_o,
   input wire logic [8:0]              bus_vector_o,
   input wire logic                    bus_vector_oe_o,
   input wire ppbi_pkg::ppbi_prn_out_t prn_o,
   input wire ppbi_pkg::ppbi_remote_t  remote_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   logic hit;
   assign hit = (bus_req_i.addr[17:3] == DEV_ADDR) && bus_req_i.addr[2];
   localparam int STB_LEN = `PPBI_CYC_NS(`PPBI_STROBE_NS);
   localparam int REM_LEN = `PPBI_CYC_NS(`PPBI_REM_PULSE_NS);
   // Pulse widths are counted, since a long repetition would be too slow to unroll
   logic [7:0] stb_len_ff;
   logic [7:0] rem_len_ff;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         stb_len_ff <= 8'h00;
         rem_len_ff <= 8'h00;
      end else begin
         stb_len_ff <= prn_o.strobe ? stb_len_ff + 8'h01 : 8'h00;
         rem_len_ff <= !remote_o.buffer_clear_n ? rem_len_ff + 8'h01 : 8'h00;
      end
   end
   AST_SSYN_HIT: assert property ($rose(bus_req_i.msyn) && hit |=> bus_ssyn_o)
      else $error("own register not answered");
   AST_SSYN_MISS: assert property ($rose(bus_req_i.msyn) && !hit |=> !bus_ssyn_o)
      else $error("foreign address answered");
   AST_BR_LEVEL: assert property (bus_br_o != 4'h0 |-> bus_br_o == 4'(1 << (PRIORITY - 4)))
      else $error("request on wrong level");
   AST_GRANT_PASS: assert property (bus_br_o == 4'h0 && !bus_sack_o && !bus_bbsy_o ##1
      bus_br_o == 4'h0 && !bus_sack_o && !bus_bbsy_o |-> bus_bg_out_o == $past(bus_bg_in_i))
      else $error("grant not passed on");
   AST_SACK: assert property (bus_br_o != 4'h0 && bus_bg_in_i |-> ##[0:2] bus_sack_o)
      else $error("grant not acknowledged");
   // Bus state is judged on the edge of the state change, two before busy shows
   AST_BBSY_TAKE: assert property ($rose(bus_bbsy_o) |-> !$past(bus_bbsy_i, 2) &&
      !$past(bus_ssyn_in_i, 2) && !$past(bus_bg_in_i, 2))
      else $error("bus taken while busy");
   AST_VECTOR: assert property (bus_vector_oe_o |-> bus_bbsy_o && bus_vector_o == {VECTOR, 2'b00})
      else $error("bad vector");
   AST_RELEASE: assert property (bus_bbsy_o && bus_ssyn_in_i |-> ##[1:2] !bus_bbsy_o)
      else $error("bus not released");
   AST_LOCKOUT: assert property ($fell(bus_bbsy_o) |-> bus_br_o == 4'h0 [*8])
      else $error("request repeated");
   AST_PRIME: assert property (bus_init_i |=> !prn_o.prime_n)
      else $error("initialize not forwarded");
   AST_STROBE: assert property ($fell(prn_o.strobe) |-> stb_len_ff == 8'(STB_LEN))
      else $error("strobe width off");
   AST_REMOTE: assert property ($rose(remote_o.buffer_clear_n) |-> rem_len_ff == 8'(REM_LEN))
      else $error("remote pulse width off");
endmodule
bind ppbi_core ppbi_core_props #(.DEV_ADDR(DEV_ADDR), .VECTOR(VECTOR), .PRIORITY(PRIORITY)) u_props (
   .clock_i, .rst_i, .bus_req_i, .bus_init_i, .bus_ssyn_o, .bus_bg_in_i, .bus_bbsy_i, .bus_ssyn_in_i,
   .bus_br_o, .bus_bg_out_o, .bus_sack_o, .bus_bbsy_o, .bus_vector_o, .bus_vector_oe_o, .prn_o, .remote_o);
`default_nettype wire

// *** dv/ppbi_printer_model.sv ***
// Printer mechanism model: ready edge after each strobe or remote pulse
`timescale 1ns/1ps
`default_nettype none
module ppbi_printer_model (
   // Clock and reset
   input  wire logic                    clock_i,
   input  wire logic                    rst_i,
   // Controller side
   input  wire ppbi_pkg::ppbi_prn_out_t prn_i,
   input  wire ppbi_pkg::ppbi_remote_t  remote_i,
   input  wire logic [7:0]              slow_i,
   output logic                         accept_o
);
   logic [8:0]             cnt_ff;
   logic                   stb_ff;
   ppbi_pkg::ppbi_remote_t remote_form_feed;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff   <= 9'h000;
         stb_ff   <= 1'b0;
         remote_form_feed   <= 4'hf;
         accept_o <= 1'b0;
      end else begin
         stb_ff <= prn_i.strobe;
         remote_form_feed <= remote_i;
         // Not ready while busy, so every acceptance is a fresh rising edge
         if (prn_i.strobe || remote_i != 4'hf) begin
            accept_o <= 1'b0;
         end else if (cnt_ff == 9'h001) begin
            accept_o <= 1'b1;
         end
         if ((stb_ff && !prn_i.strobe) || (remote_i & ~remote_form_feed) != 4'h0) begin
            cnt_ff <= {1'b0, slow_i} + 9'h001;
         end else if (cnt_ff != 9'h000) begin
            cnt_ff <= cnt_ff - 9'h001;
         end
      end
   end
endmodule
`default_nettype wire

// *** dv/test_printer_plotter_bus_interface.sv ***
// Self-checking testbench for the printer/plotter bus interface
`timescale 1ns/1ps
`default_nettype none
module test_printer_plotter_bus_interface;
   localparam logic [17:3] DEV = 15'h7fe9;
   logic clock_i = 1'b0, rst_i = 1'b1, init = 1'b0, bg_in = 1'b0, bbsy_in = 1'b0, ssyn_in = 1'b0;
   logic hw_f = 1'b0, paper_f = 1'b0, accept, ssyn, bg_out, sack, bbsy, intr, vec_oe, plot;
   logic [15:0] rdata, rd;
   logic [7:4] br;
   logic [8:0] vec;
   logic [7:0] slow = 8'h02;
   ppbi_pkg::ppbi_bus_req_t req = '0;
   ppbi_pkg::ppbi_prn_out_t prn;
   ppbi_pkg::ppbi_remote_t rem;
   int miscompares = 0, num_checks = 0, n;
   always #2.5 clock_i = ~clock_i;
   ppbi_core #(.ERROR_CYCLES(50)) u_dut (.clock_i(clock_i), .rst_i(rst_i), .bus_req_i(req),
      .bus_init_i(init), .bus_ssyn_o(ssyn), .bus_rdata_o(rdata), .bus_bg_in_i(bg_in), .bus_bbsy_i(bbsy_in),
      .bus_ssyn_in_i(ssyn_in), .bus_br_o(br), .bus_bg_out_o(bg_out), .bus_sack_o(sack), .bus_bbsy_o(bbsy),
      .bus_intr_o(intr), .bus_vector_o(vec), .bus_vector_oe_o(vec_oe), .printer_accept_i(accept),
      .printer_hw_fault_i(hw_f), .printer_paper_fault_i(paper_f), .prn_o(prn), .remote_o(rem),
      .plot_mode_o(plot));
   ppbi_printer_model u_prn (.clock_i(clock_i), .rst_i(rst_i), .prn_i(prn), .remote_i(rem),
      .slow_i(slow), .accept_o(accept));
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) begin
         @(posedge clock_i);
         #1;
      end
   endtask
   function automatic logic sel(input int k);
      case (k)
         0: return ssyn;
         1: return prn.strobe;
         2: return sack;
         3: return bbsy;
         4: return |br;
         default: return accept;
      endcase
   endfunction
   // Bounded wait; a hang ends the run through the closing report
   // Acceptance is a fresh rise: a ready left from the last transfer drops first
   task automatic wait_for(input int k, input logic v);
      if (k == 5 && v === 1'b1) wait_for(5, 1'b0);
      for (n = 0; n < 400 && sel(k) !== v; n++) tick(1);
      if (n == 400) begin
         miscompares++;
         $display("BAD t=%0t wait=%0h exp=%0h", $time, k, v);
         wrap_up();
      end
   endtask
   // Request held until the reply is seen, then released
   task automatic bus_op(input logic [2:0] off, input ppbi_pkg::ppbi_bus_op_t op, input logic [15:0] d);
      req = '{addr: {DEV, off}, op: op, msyn: 1'b1, wdata: d};
      wait_for(0, 1'b1);
      rd = rdata;
      req.msyn = 1'b0;
      tick(2);
   endtask
   task automatic wr(input logic [2:0] off, input logic [15:0] d);
      bus_op(off, ppbi_pkg::PPBI_DATO, d);
   endtask
   task automatic chk_status(input logic [15:0] exp);
      bus_op(3'h4, ppbi_pkg::PPBI_DATI, 16'h0000);
      chk(rd, exp);
   endtask
   task automatic t_reset();
      chk_status(16'h0080);
      bus_op(3'h4, ppbi_pkg::PPBI_DATIP, 16'h0000);
      chk(rd, 16'h0080);
      req = '{addr: {DEV, 3'h0}, op: ppbi_pkg::PPBI_DATI, msyn: 1'b1, wdata: 16'h0000};
      tick(10);
      chk({15'h0, ssyn}, 16'h0000);
      req.msyn = 1'b0;
      tick(2);
   endtask
   task automatic t_char();
      bus_op(3'h6, ppbi_pkg::PPBI_DATOB, 16'hff41);
      chk_status(16'h0000);
      wait_for(1, 1'b1);
      chk({8'h00, prn.data}, 16'h0041);
      chk(16'(n > 84 && n < 106), 16'h0001);
      wait_for(5, 1'b1);
      tick(2);
      chk_status(16'h0080);
      // High byte only: the buffer must not load
      bus_op(3'h7, ppbi_pkg::PPBI_DATOB, 16'h4200);
      chk_status(16'h0080);
   endtask
   task automatic t_lf(input logic [7:0] c);
      slow = c[1] ? 8'h1e : 8'h02;
      wr(3'h6, {8'h00, c});
      wait_for(1, 1'b1);
      chk({8'h00, prn.data}, {8'h00, c[7:3], 3'h5});
      wait_for(5, 1'b1);
      tick(2);
      chk_status(16'h0000);
      wait_for(1, 1'b1);
      chk({8'h00, prn.data}, {8'h00, c});
      wait_for(5, 1'b1);
      tick(2);
      chk_status(16'h0080);
   endtask
   task automatic t_plot();
      wr(3'h4, 16'h0001);
      chk_status(16'h0081);
      chk({15'h0, plot}, 16'h0001);
      wr(3'h6, 16'h000a);
      wait_for(1, 1'b1);
      chk({8'h00, prn.data}, 16'h000a);
      wait_for(5, 1'b1);
      wr(3'h4, 16'h0000);
      chk_status(16'h0080);
   endtask
   task automatic t_remote();
      logic [3:0] m [4] = '{4'h1, 4'h4, 4'h2, 4'h8};
      for (int i = 0; i < 4; i++) begin
         wr(3'h4, 16'(1 << (i + 1)));
         chk({12'h000, rem}, {12'h000, ~m[i]});
         chk_status(16'h0000);
         wait_for(5, 1'b1);
         tick(2);
         bus_op(3'h4, ppbi_pkg::PPBI_DATI, 16'h0000);
         chk(rd & 16'h0080, 16'h0080);
      end
   endtask
   task automatic t_irq();
      bg_in = 1'b1;
      tick(3);
      chk({15'h0, bg_out}, 16'h0001);
      bg_in = 1'b0;
      wr(3'h4, 16'h0040);
      wait_for(4, 1'b1);
      chk({12'h000, br}, 16'h0001);
      bg_in = 1'b1;
      wait_for(2, 1'b1);
      chk({15'h0, bg_out}, 16'h0000);
      bg_in = 1'b0;
      wait_for(3, 1'b1);
      chk({intr, vec_oe, 5'h00, vec}, 16'hc080);
      ssyn_in = 1'b1;
      wait_for(3, 1'b0);
      ssyn_in = 1'b0;
      tick(20);
      chk({12'h000, br}, 16'h0000);
      wr(3'h4, 16'h0000);
      wr(3'h4, 16'h0040);
      wait_for(4, 1'b1);
      wr(3'h4, 16'h0000);
      tick(3);
      chk({12'h000, br}, 16'h0000);
   endtask
   task automatic t_error();
      hw_f = 1'b1;
      tick(2);
      hw_f = 1'b0;
      chk_status(16'h8000);
      paper_f = 1'b1;
      tick(2);
      paper_f = 1'b0;
      tick(20);
      chk_status(16'h8000);
      tick(60);
      chk_status(16'h0080);
   endtask
   task automatic t_init();
      wr(3'h6, 16'h0041);
      wr(3'h4, 16'h0001);
      init = 1'b1;
      tick(1);
      init = 1'b0;
      chk({15'h0, prn.prime_n}, 16'h0000);
      tick(2);
      chk({15'h0, plot}, 16'h0000);
      chk_status(16'h0080);
   endtask
   initial begin
      repeat (8) @(posedge clock_i);
      #1;
      rst_i = 1'b0;
      tick(1);
      t_reset();
      t_char();
      t_lf(8'h0a);
      t_lf(8'h0c);
      t_plot();
      t_remote();
      t_irq();
      t_error();
      t_init();
      wrap_up();
   end
endmodule
`default_nettype wire

// *** rtl/ppbi_core.sv ***
// Printer/plotter bus interface: registers, printer handshake, interrupt master
`timescale 1ns/1ps
`default_nettype none
`include "ppbi_regs.svh"
module ppbi_core #(
   parameter logic [17:3] DEV_ADDR      = 15'h7fe9,
   parameter logic [6:0]  VECTOR        = `PPBI_VECTOR_RESET,
   parameter int          PRIORITY      = 4,
   parameter int          ERROR_CYCLES  = `PPBI_ERROR_CYCLES
) (
   // Clock and reset
   input  wire logic                   clock_i,
   input  wire logic                   rst_i,
   // Bus slave
   input  wire ppbi_pkg::ppbi_bus_req_t bus_req_i,
   input  wire logic                   bus_init_i,
   output logic                        bus_ssyn_o,
   output logic [15:0]                 bus_rdata_o,
   // Bus mastership for interrupts
   input  wire logic                   bus_bg_in_i,
   input  wire logic                   bus_bbsy_i,
   input  wire logic                   bus_ssyn_in_i,
   output logic [7:4]                  bus_br_o,
   output logic                        bus_bg_out_o,
   output logic                        bus_sack_o,
   output logic                        bus_bbsy_o,
   output logic                        bus_intr_o,
   output logic [8:0]                  bus_vector_o,
   output logic                        bus_vector_oe_o,
   // Printer port
   input  wire logic                   printer_accept_i,
   input  wire logic                   printer_hw_fault_i,
   input  wire logic                   printer_paper_fault_i,
   output ppbi_pkg::ppbi_prn_out_t      prn_o,
   output ppbi_pkg::ppbi_remote_t       remote_o,
   output logic                        plot_mode_o
);
   localparam int SETTLE_CYC = `PPBI_CYC_NS(`PPBI_SETTLE_NS);
   localparam int STROBE_CYC = `PPBI_CYC_NS(`PPBI_STROBE_NS);
   localparam int REM_CYC    = `PPBI_CYC_NS(`PPBI_REM_PULSE_NS);
   localparam int SECOND_CYC = `PPBI_CYC_NS(`PPBI_SECOND_NS);
   localparam int GATE_CYC   = `PPBI_CYC_NS(`PPBI_GATE_NS);

   // Address decode
   logic       hit;
   logic       sel_status;
   logic       sel_data;
   logic       out_low;
   logic       in_op;
   logic       wr_status;
   logic       wr_data;
   logic       msyn_q_ff;
   logic       access;
   assign hit        = bus_req_i.msyn && (bus_req_i.addr[17:3] == DEV_ADDR);
   assign sel_status = hit && (bus_req_i.addr[2:1] == `PPBI_SEL_STATUS);
   assign sel_data   = hit && (bus_req_i.addr[2:1] == `PPBI_SEL_DATA);
   // High-byte-only DATOB does not reach the low byte
   assign out_low = (bus_req_i.op == ppbi_pkg::PPBI_DATO) ||
                    ((bus_req_i.op == ppbi_pkg::PPBI_DATOB) && !bus_req_i.addr[0]);
   assign in_op   = (bus_req_i.op == ppbi_pkg::PPBI_DATI) || (bus_req_i.op == ppbi_pkg::PPBI_DATIP);
   assign access  = (sel_status || sel_data) && !msyn_q_ff;
   assign wr_status = access && sel_status && out_low;
   assign wr_data   = access && sel_data && out_low;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         msyn_q_ff <= 1'b0;
      end else begin
         msyn_q_ff <= (sel_status || sel_data);
      end
   end

   // Registers
   logic [7:0] data_ff;
   logic       ie_ff;
   logic       mode_ff;
   logic [3:0] rem_bits_ff;
   logic       done_ff;
   logic       hold_ff;
   logic       error_ff;
   logic       gate_ff;
   logic [31:0] err_cnt_ff;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         data_ff <= 8'h00;
      end else if (wr_data) begin
         data_ff <= bus_req_i.wdata[7:0];
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ie_ff       <= 1'b0;
         mode_ff     <= 1'b0;
         rem_bits_ff <= 4'h0;
      end else if (bus_init_i) begin
         ie_ff       <= 1'b0;
         mode_ff     <= 1'b0;
         rem_bits_ff <= 4'h0;
      end else if (wr_status) begin
         ie_ff       <= bus_req_i.wdata[`PPBI_BIT_IE];
         mode_ff     <= bus_req_i.wdata[`PPBI_BIT_MODE];
         rem_bits_ff <= {bus_req_i.wdata[`PPBI_BIT_BUFFER_CLEAR], bus_req_i.wdata[`PPBI_BIT_EOT],
                         bus_req_i.wdata[`PPBI_BIT_FORM_FEED], bus_req_i.wdata[`PPBI_BIT_LINE_TERM]};
      end
   end

   // Remote function pulses start the cycle after the status write is accepted
   logic [7:0] rem_cnt_ff;
   logic       wr_status_q_ff;
   logic       rem_start;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wr_status_q_ff <= 1'b0;
      end else begin
         wr_status_q_ff <= wr_status;
      end
   end
   assign rem_start = wr_status_q_ff && (rem_bits_ff != 4'h0);

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rem_cnt_ff <= 8'h00;
      end else if (bus_init_i) begin
         rem_cnt_ff <= 8'h00;
      end else if (rem_start) begin
         rem_cnt_ff <= 8'(REM_CYC);
      end else if (rem_cnt_ff != 8'h00) begin
         rem_cnt_ff <= rem_cnt_ff - 8'h01;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         remote_o <= '1;
      end else begin
         remote_o.buffer_clear_n   <= !(rem_start ? rem_bits_ff[3] : (rem_cnt_ff > 8'h01) && rem_bits_ff[3]);
         remote_o.eot_n       <= !(rem_start ? rem_bits_ff[2] : (rem_cnt_ff > 8'h01) && rem_bits_ff[2]);
         remote_o.form_feed_n <= !(rem_start ? rem_bits_ff[1] : (rem_cnt_ff > 8'h01) && rem_bits_ff[1]);
         remote_o.line_term_n <= !(rem_start ? rem_bits_ff[0] : (rem_cnt_ff > 8'h01) && rem_bits_ff[0]);
      end
   end

   // Check gate and LF/FF detect
   logic [7:0] gate_cnt_ff;
   logic       lf_ff_detect;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         gate_cnt_ff <= 8'h00;
      end else if (wr_data) begin
         gate_cnt_ff <= 8'(GATE_CYC);
      end else if (gate_cnt_ff != 8'h00) begin
         gate_cnt_ff <= gate_cnt_ff - 8'h01;
      end
   end
   assign gate_ff = (gate_cnt_ff != 8'h00);
   // Plot data is a bitmap, so no CR conversion there
   assign lf_ff_detect = gate_ff && !mode_ff &&
                         ((data_ff == `PPBI_CODE_LF) || (data_ff == `PPBI_CODE_FF));

   // Printer sequencer
   ppbi_pkg::ppbi_prn_state_t pstate_ff;
   logic [7:0] pcnt_ff;
   logic       accept_q_ff;
   logic       accept_rise;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         accept_q_ff <= 1'b0;
      end else begin
         accept_q_ff <= printer_accept_i;
      end
   end
   assign accept_rise = printer_accept_i && !accept_q_ff;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pstate_ff <= ppbi_pkg::PPBI_P_IDLE;
         pcnt_ff   <= 8'h00;
      end else if (bus_init_i) begin
         pstate_ff <= ppbi_pkg::PPBI_P_IDLE;
         pcnt_ff   <= 8'h00;
      end else if (wr_data) begin
         pstate_ff <= ppbi_pkg::PPBI_P_SETTLE;
         pcnt_ff   <= 8'(SETTLE_CYC);
      end else begin
         unique case (pstate_ff)
            ppbi_pkg::PPBI_P_IDLE: begin
               pcnt_ff <= 8'h00;
            end
            ppbi_pkg::PPBI_P_SETTLE, ppbi_pkg::PPBI_P_GAP: begin
               if (pcnt_ff <= 8'h01) begin
                  pstate_ff <= ppbi_pkg::PPBI_P_STROBE;
                  pcnt_ff   <= 8'(STROBE_CYC);
               end else begin
                  pcnt_ff <= pcnt_ff - 8'h01;
               end
            end
            ppbi_pkg::PPBI_P_STROBE: begin
               if (pcnt_ff <= 8'h01) begin
                  pstate_ff <= ppbi_pkg::PPBI_P_WAIT;
               end
               pcnt_ff <= pcnt_ff - 8'h01;
            end
            ppbi_pkg::PPBI_P_WAIT: begin
               if (accept_rise && hold_ff) begin
                  pstate_ff <= ppbi_pkg::PPBI_P_GAP;
                  pcnt_ff   <= 8'(SECOND_CYC);
               end else if (accept_rise) begin
                  pstate_ff <= ppbi_pkg::PPBI_P_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         hold_ff <= 1'b0;
      end else if (bus_init_i || wr_data) begin
         hold_ff <= 1'b0;
      end else if (lf_ff_detect) begin
         hold_ff <= 1'b1;
      end else if (accept_rise && pstate_ff == ppbi_pkg::PPBI_P_WAIT) begin
         hold_ff <= 1'b0;
      end
   end

   // Done: set after the last accept, cleared by load or remote pulse
   logic rem_leading;
   assign rem_leading = rem_start && (rem_bits_ff != 4'h0);
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         done_ff <= 1'b1;
      end else if (bus_init_i) begin
         done_ff <= 1'b1;
      end else if (wr_data || rem_leading) begin
         done_ff <= 1'b0;
      end else if (accept_rise && pstate_ff == ppbi_pkg::PPBI_P_WAIT && !hold_ff) begin
         done_ff <= 1'b1;
      end else if (accept_rise && rem_bits_ff != 4'h0 && rem_cnt_ff == 8'h00 &&
                   pstate_ff == ppbi_pkg::PPBI_P_IDLE) begin
         done_ff <= 1'b1;
      end
   end

   // Error stretch
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         err_cnt_ff <= 32'h0;
      end else if (printer_hw_fault_i || printer_paper_fault_i) begin
         err_cnt_ff <= 32'(ERROR_CYCLES);
      end else if (err_cnt_ff != 32'h0) begin
         err_cnt_ff <= err_cnt_ff - 32'h1;
      end
   end
   assign error_ff = (err_cnt_ff != 32'h0);

   // Printer outputs
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         prn_o <= '{data: 8'h00, strobe: 1'b0, prime_n: 1'b1};
      end else begin
         prn_o.data    <= (hold_ff || lf_ff_detect) ? {data_ff[7:3], `PPBI_CR_LOW3} : data_ff;
         prn_o.strobe  <= (pstate_ff == ppbi_pkg::PPBI_P_STROBE);
         prn_o.prime_n <= !bus_init_i;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         plot_mode_o <= 1'b0;
      end else begin
         plot_mode_o <= mode_ff;
      end
   end

   // Slave answer
   logic [15:0] status_rd;
   always_comb begin
      status_rd = 16'h0000;
      status_rd[`PPBI_BIT_IE]    = ie_ff;
      status_rd[`PPBI_BIT_DONE]  = done_ff && !error_ff;
      status_rd[`PPBI_BIT_ERROR] = error_ff;
      status_rd[`PPBI_BIT_MODE]  = mode_ff;
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         bus_ssyn_o  <= 1'b0;
         bus_rdata_o <= 16'h0000;
      end else begin
         bus_ssyn_o  <= sel_status || sel_data;
         bus_rdata_o <= (sel_status && in_op) ? status_rd : 16'h0000;
      end
   end

   // Interrupt master
   logic irq_src;
   logic irq_permit_line;
   logic irq_qual;
   ppbi_pkg::ppbi_irq_state_t istate_ff;
   assign irq_src         = done_ff || error_ff;
   assign irq_permit_line = ie_ff;
   assign irq_qual        = irq_src && irq_permit_line;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         istate_ff <= ppbi_pkg::PPBI_IDLE;
      end else if (bus_init_i) begin
         istate_ff <= ppbi_pkg::PPBI_IDLE;
      end else begin
         unique case (istate_ff)
            ppbi_pkg::PPBI_IDLE: begin
               if (irq_qual) begin
                  istate_ff <= ppbi_pkg::PPBI_REQ;
               end
            end
            ppbi_pkg::PPBI_REQ: begin
               if (!irq_qual) begin
                  istate_ff <= ppbi_pkg::PPBI_IDLE;
               end else if (bus_sack_o && !bus_bbsy_i && !bus_ssyn_in_i && !bus_bg_in_i) begin
                  istate_ff <= ppbi_pkg::PPBI_MASTER;
               end
            end
            ppbi_pkg::PPBI_MASTER: begin
               if (bus_ssyn_in_i) begin
                  istate_ff <= ppbi_pkg::PPBI_LOCKOUT;
               end
            end
            ppbi_pkg::PPBI_LOCKOUT: begin
               if (!irq_qual) begin
                  istate_ff <= ppbi_pkg::PPBI_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         bus_br_o        <= 4'h0;
         bus_bg_out_o    <= 1'b0;
         bus_sack_o      <= 1'b0;
         bus_bbsy_o      <= 1'b0;
         bus_intr_o      <= 1'b0;
         bus_vector_o    <= 9'h000;
         bus_vector_oe_o <= 1'b0;
      end else begin
         bus_br_o <= (istate_ff == ppbi_pkg::PPBI_REQ && !bus_sack_o) ?
                     4'(1 << (PRIORITY - 4)) : 4'h0;
         bus_bg_out_o <= (istate_ff != ppbi_pkg::PPBI_REQ) && bus_bg_in_i;
         bus_sack_o   <= (istate_ff == ppbi_pkg::PPBI_REQ) && irq_qual && (bus_bg_in_i || bus_sack_o);
         bus_bbsy_o   <= (istate_ff == ppbi_pkg::PPBI_MASTER) && !bus_ssyn_in_i;
         bus_intr_o   <= (istate_ff == ppbi_pkg::PPBI_MASTER) && !bus_ssyn_in_i;
         bus_vector_o <= {VECTOR, 2'b00};
         bus_vector_oe_o <= (istate_ff == ppbi_pkg::PPBI_MASTER) && !bus_ssyn_in_i;
      end
   end
endmodule
`default_nettype wire
